// *** logic/atoc_config_regs.sv ***
// Purpose: apb register bank for channel 2 analog, strobe timing, loop and pattern window
// Assumes: one clock; pixel period made of PHASE_STEPS enable steps from a divider
// Notes: zero-wait apb slave; unmapped addresses read zero and answer pslverr
//
// The APB slave port was left to the implementer.
module atoc_config_regs #(
    parameter int STEP_DIV = 1
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire atoc_pkg::atoc_apb_req_s i_apb,
    output atoc_pkg::atoc_apb_rsp_s o_apb,
    input wire logic i_correlated_double_sampling_mode,
    input wire logic i_line_start_input,
    output atoc_pkg::atoc_analog_s o_analog,
    output logic o_loop_reset,
    output logic o_reset_strobe,
    output logic o_capture_strobe,
    output logic o_period_start,
    output logic o_pattern_valid
);
    import atoc_pkg::*;

    typedef struct packed {
        logic [7:0] coarse_lo;
        logic [7:0] fine_hi;
        logic [7:0] fine_lo;
        logic [7:0] gain;
        logic [7:0] rst_rise;
        logic [7:0] rst_fall;
        logic [7:0] cap_rise;
        logic [7:0] cap_fall;
        logic [7:0] band;
        logic [7:0] loop_ctl;
        logic [7:0] pst_hi;
        logic [7:0] pst_lo;
        logic [7:0] pwd_hi;
        logic [7:0] pwd_lo;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic loop_reset;
        logic [15:0] div;
        logic step;
        logic [5:0] phase;
        logic period_start;
        atoc_analog_s analog;
    } atoc_cr_s;
    atoc_cr_s st_q, st_d;

    logic [5:0] idx;
    logic hit;
    logic [7:0] rd_byte;
    logic rst_strobe_w;
    logic cap_strobe_w;
    logic pattern_w;

    initial begin
        if (STEP_DIV < 1 || STEP_DIV > 65535) $error("atoc_config_regs: STEP_DIV out of range");
    end

    assign idx = i_apb.paddr[7:2];

    always_comb begin
        hit = 1'b1;
        rd_byte = 8'h00;
        case (idx)
            IDX_COARSE_LO: rd_byte = st_q.coarse_lo;
            IDX_FINE_HI: rd_byte = {7'h00, st_q.fine_hi[FINE_BIT8]};
            IDX_FINE_LO: rd_byte = st_q.fine_lo;
            IDX_GAIN: rd_byte = st_q.gain;
            IDX_RST_RISE: rd_byte = {2'h0, st_q.rst_rise[IDX_MSB:0]};
            IDX_RST_FALL: rd_byte = {2'h0, st_q.rst_fall[IDX_MSB:0]};
            IDX_CAP_RISE: rd_byte = {2'h0, st_q.cap_rise[IDX_MSB:0]};
            IDX_CAP_FALL: rd_byte = {2'h0, st_q.cap_fall[IDX_MSB:0]};
            IDX_BAND: rd_byte = st_q.band;
            IDX_LOOP: rd_byte = st_q.loop_ctl;
            IDX_PST_HI: rd_byte = st_q.pst_hi;
            IDX_PST_LO: rd_byte = st_q.pst_lo;
            IDX_PWD_HI: rd_byte = st_q.pwd_hi;
            IDX_PWD_LO: rd_byte = st_q.pwd_lo;
            default: hit = 1'b0;
        endcase
        if (i_apb.paddr[11:8] != 4'h0 || i_apb.paddr[1:0] != 2'h0) begin
            hit = 1'b0;
        end
    end

    always_comb begin
        st_d = st_q;
        st_d.pready = 1'b0;
        st_d.pslverr = 1'b0;
        st_d.loop_reset = 1'b0;
        // loop reset bit self-clears one cycle after the write
        st_d.loop_ctl[LOOP_RST_BIT] = 1'b0;
        // setup phase: answer in the access phase's first cycle
        if (i_apb.psel && !i_apb.penable) begin
            st_d.pready = 1'b1;
            st_d.pslverr = !hit;
            st_d.prdata = (hit && !i_apb.pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
        end
        if (i_apb.psel && i_apb.penable && st_q.pready && i_apb.pwrite && hit
                && i_apb.pstrb[0]) begin
            case (idx)
                IDX_COARSE_LO: st_d.coarse_lo = i_apb.pwdata[7:0];
                IDX_FINE_HI: st_d.fine_hi = {7'h00, i_apb.pwdata[FINE_BIT8]};
                IDX_FINE_LO: st_d.fine_lo = i_apb.pwdata[7:0];
                IDX_GAIN: st_d.gain = i_apb.pwdata[7:0];
                IDX_RST_RISE: st_d.rst_rise = {2'h0, i_apb.pwdata[IDX_MSB:0]};
                IDX_RST_FALL: st_d.rst_fall = {2'h0, i_apb.pwdata[IDX_MSB:0]};
                IDX_CAP_RISE: st_d.cap_rise = {2'h0, i_apb.pwdata[IDX_MSB:0]};
                IDX_CAP_FALL: st_d.cap_fall = {2'h0, i_apb.pwdata[IDX_MSB:0]};
                IDX_BAND: st_d.band = {1'b0, i_apb.pwdata[BAND_MSB:BAND_LSB], 2'h0,
                                       i_apb.pwdata[RANGE_MSB:RANGE_LSB]};
                IDX_LOOP: begin
                    st_d.loop_ctl = i_apb.pwdata[7:0];
                    st_d.loop_reset = i_apb.pwdata[LOOP_RST_BIT];
                end
                IDX_PST_HI: st_d.pst_hi = i_apb.pwdata[7:0];
                IDX_PST_LO: st_d.pst_lo = i_apb.pwdata[7:0];
                IDX_PWD_HI: st_d.pwd_hi = i_apb.pwdata[7:0];
                IDX_PWD_LO: st_d.pwd_lo = i_apb.pwdata[7:0];
                default: st_d.pslverr = 1'b0;
            endcase
        end
        // phase step divider: PHASE_STEPS steps make one pixel period
        st_d.step = 1'b0;
        st_d.period_start = 1'b0;
        if (st_q.div == 16'(STEP_DIV - 1)) begin
            st_d.div = 16'h0000;
            st_d.step = 1'b1;
        end else begin
            st_d.div = st_q.div + 16'h0001;
        end
        if (st_q.step) begin
            st_d.phase = st_q.phase + 6'h01;
            st_d.period_start = (st_q.phase == 6'(PHASE_STEPS - 1));
        end
        // host is trusted with band and range codes; values pass through as stored
        st_d.analog.coarse_offset_ch2 = {1'b0, st_q.coarse_lo};
        st_d.analog.fine_offset_ch2 = {st_q.fine_hi[FINE_BIT8], st_q.fine_lo};
        st_d.analog.gain_amp_ch2 = st_q.gain;
        st_d.analog.clock_band = st_q.band[BAND_MSB:BAND_LSB];
        st_d.analog.loop_range = st_q.band[RANGE_MSB:RANGE_LSB];
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_q <= '0;
            st_q.coarse_lo <= RST_COARSE_LO;
            st_q.fine_hi <= RST_FINE_HI;
            st_q.fine_lo <= RST_FINE_LO;
            st_q.gain <= RST_GAIN;
            st_q.rst_rise <= RST_RST_RISE;
            st_q.rst_fall <= RST_RST_FALL;
            st_q.cap_rise <= RST_CAP_RISE;
            st_q.cap_fall <= RST_CAP_FALL;
            st_q.band <= RST_BAND;
            st_q.loop_ctl <= RST_LOOP & 8'hfe;
            st_q.pst_hi <= RST_PATTERN;
            st_q.pst_lo <= RST_PATTERN;
            st_q.pwd_hi <= RST_PATTERN;
            st_q.pwd_lo <= RST_PATTERN;
        end else begin
            st_q <= st_d;
        end
    end

    // reset strobe only runs in double sampling mode
    atoc_edge_strobe #(.W(6)) u_reset_strobe (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_enable(i_correlated_double_sampling_mode),
        .i_step(st_q.step),
        .i_phase(st_q.phase),
        .i_rise(st_q.rst_rise[IDX_MSB:0]),
        .i_fall(st_q.rst_fall[IDX_MSB:0]),
        .o_strobe(rst_strobe_w)
    );

    atoc_edge_strobe #(.W(6)) u_capture_strobe (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_enable(1'b1),
        .i_step(st_q.step),
        .i_phase(st_q.phase),
        .i_rise(st_q.cap_rise[IDX_MSB:0]),
        .i_fall(st_q.cap_fall[IDX_MSB:0]),
        .o_strobe(cap_strobe_w)
    );

    atoc_pattern_window #(.W(16)) u_pattern (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_line(i_line_start_input),
        .i_pixel(st_q.period_start),
        .i_start({st_q.pst_hi, st_q.pst_lo}),
        .i_width({st_q.pwd_hi, st_q.pwd_lo}),
        .o_valid(pattern_w)
    );

    // strobes re-registered so every output leaves a flip-flop
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_reset_strobe <= 1'b0;
            o_capture_strobe <= 1'b0;
            o_pattern_valid <= 1'b0;
        end else begin
            o_reset_strobe <= rst_strobe_w;
            o_capture_strobe <= cap_strobe_w;
            o_pattern_valid <= pattern_w;
        end
    end

    assign o_apb.prdata = st_q.prdata;
    assign o_apb.pready = st_q.pready;
    assign o_apb.pslverr = st_q.pslverr;
    assign o_analog = st_q.analog;
    assign o_loop_reset = st_q.loop_reset;
    assign o_period_start = st_q.period_start;
endmodule

// *** logic/atoc_edge_strobe.sv ***
// Purpose: one strobe placed between two phase indices of a pixel period
// Assumes: phase counts 0 to steps-1 from the start of each period
// Notes: equal rise and fall gives no pulse
module atoc_edge_strobe #(
    parameter int W = 6
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_enable,
    input wire logic i_step,
    input wire logic [W-1:0] i_phase,
    input wire logic [W-1:0] i_rise,
    input wire logic [W-1:0] i_fall,
    output logic o_strobe
);
    typedef struct packed {
        logic level;
    } atoc_es_s;
    atoc_es_s st_q, st_d;

    initial begin
        if (W < 1) $error("atoc_edge_strobe: width too small");
    end

    always_comb begin
        st_d = st_q;
        if (!i_enable) begin
            st_d.level = 1'b0;
        end else if (i_step) begin
            if (i_phase == i_fall) begin
                st_d.level = 1'b0;
            end else if (i_phase == i_rise) begin
                st_d.level = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_strobe = st_q.level;
endmodule

// *** logic/atoc_pattern_window.sv ***
// Purpose: marks the valid test-pattern pixel region of each line
// Assumes: i_pixel is a one-cycle pulse per pixel, i_line a level
// Notes: a zero width gives no region; counts restart at each rising line edge
module atoc_pattern_window #(
    parameter int W = 16
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_line,
    input wire logic i_pixel,
    input wire logic [W-1:0] i_start,
    input wire logic [W-1:0] i_width,
    output logic o_valid
);
    typedef struct packed {
        logic line_d1;
        logic busy;
        logic valid;
        logic [W-1:0] cnt;
    } atoc_pw_s;
    atoc_pw_s st_q, st_d;

    initial begin
        if (W < 2) $error("atoc_pattern_window: width too small");
    end

    always_comb begin
        st_d = st_q;
        st_d.line_d1 = i_line;
        if (i_line && !st_q.line_d1) begin
            st_d.busy = 1'b1;
            st_d.valid = 1'b0;
            st_d.cnt = '0;
        end else if (st_q.busy && i_pixel) begin
            if (!st_q.valid) begin
                if (st_q.cnt == i_start) begin
                    st_d.valid = (i_width != '0);
                    st_d.busy = (i_width != '0);
                    st_d.cnt = W'(1);
                end else begin
                    st_d.cnt = st_q.cnt + W'(1);
                end
            end else if (st_q.cnt == i_width) begin
                st_d.valid = 1'b0;
                st_d.busy = 1'b0;
            end else begin
                st_d.cnt = st_q.cnt + W'(1);
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_valid = st_q.valid;
endmodule

// *** logic/atoc_pkg.sv ***
// Purpose: constants and carriers for the channel 2 and timing configuration register bank
// Assumes: apb with 32-bit data, one register per aligned word at byte address 4 * index
// Notes: register indices are six-bit addresses; only the low byte of each word is used
// Function
// - register 0x19 holds channel 2 coarse offset bits 7:0.
// - register 0x1a bit 0 is fine offset bit 8; bits 7:1 unused.
// - register 0x1b holds channel 2 fine offset bits 7:0.
// - register 0x1c holds the eight-bit channel 2 gain setting.
// - reset strobe rises at six-bit start index, only in double sampling mode.
// - reset strobe falls at six-bit end index, only in double sampling mode.
// - capture strobe rises at six-bit start index in every mode.
// - capture strobe falls at six-bit end index; upper two bits unused.
// - writing one to loop control bit 0 resets the loop, then self-clears.
// - pattern region starts sixteen-bit pixel count after line start edge.
// - pattern region is as wide as the sixteen-bit width count.
package atoc_pkg;
    localparam logic [5:0] IDX_COARSE_LO = 6'h19;
    localparam logic [5:0] IDX_FINE_HI = 6'h1a;
    localparam logic [5:0] IDX_FINE_LO = 6'h1b;
    localparam logic [5:0] IDX_GAIN = 6'h1c;
    localparam logic [5:0] IDX_RST_RISE = 6'h20;
    localparam logic [5:0] IDX_RST_FALL = 6'h21;
    localparam logic [5:0] IDX_CAP_RISE = 6'h22;
    localparam logic [5:0] IDX_CAP_FALL = 6'h23;
    localparam logic [5:0] IDX_BAND = 6'h25;
    localparam logic [5:0] IDX_LOOP = 6'h28;
    localparam logic [5:0] IDX_PST_HI = 6'h30;
    localparam logic [5:0] IDX_PST_LO = 6'h31;
    localparam logic [5:0] IDX_PWD_HI = 6'h32;
    localparam logic [5:0] IDX_PWD_LO = 6'h33;
    localparam logic [7:0] RST_COARSE_LO = 8'hff;
    localparam logic [7:0] RST_FINE_HI = 8'h00;
    localparam logic [7:0] RST_FINE_LO = 8'hff;
    localparam logic [7:0] RST_GAIN = 8'h61;
    localparam logic [7:0] RST_RST_RISE = 8'h08;
    localparam logic [7:0] RST_RST_FALL = 8'h1c;
    localparam logic [7:0] RST_CAP_RISE = 8'h28;
    localparam logic [7:0] RST_CAP_FALL = 8'h3c;
    localparam logic [7:0] RST_BAND = 8'h02;
    localparam logic [7:0] RST_LOOP = 8'h0f;
    localparam logic [7:0] RST_PATTERN = 8'h00;
    localparam int IDX_MSB = 5;
    localparam int FINE_BIT8 = 0;
    localparam int BAND_LSB = 4;
    localparam int BAND_MSB = 6;
    localparam int RANGE_LSB = 0;
    localparam int RANGE_MSB = 1;
    localparam int LOOP_RST_BIT = 0;
    localparam int LOOP_RST_CYCLES = 1;
    localparam int PHASE_STEPS = 64;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } atoc_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } atoc_apb_rsp_s;

    typedef struct packed {
        logic [8:0] coarse_offset_ch2;
        logic [8:0] fine_offset_ch2;
        logic [7:0] gain_amp_ch2;
        logic [2:0] clock_band;
        logic [1:0] loop_range;
    } atoc_analog_s;
endpackage

// *** verification/atoc_config_monitor.sv ***
// Purpose: port checker for the config register bank
// Assumes: apb answered one cycle after setup, analog copy two edges after the write
// Notes: bound to every instance of the bank
module atoc_config_monitor #(
    parameter int STEP_DIV = 1
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire atoc_pkg::atoc_apb_req_s i_apb,
    input wire atoc_pkg::atoc_apb_rsp_s o_apb,
    input wire logic i_correlated_double_sampling_mode,
    input wire atoc_pkg::atoc_analog_s o_analog,
    input wire logic o_loop_reset,
    input wire logic o_reset_strobe,
    input wire logic o_period_start
);
    timeunit 1ns;
    timeprecision 1ps;
    import atoc_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    logic acc;
    logic set_loop;
    logic [7:0] wd;
    logic [15:0] gap_q;
    logic seen_q;
    assign acc = i_apb.psel & i_apb.penable & i_apb.pwrite & o_apb.pready & i_apb.pstrb[0];
    assign set_loop = acc & (i_apb.paddr == 12'ha0) & i_apb.pwdata[0];
    assign wd = i_apb.pwdata[7:0];
    sequence one_pulse;
        o_loop_reset ##1 !o_loop_reset;
    endsequence
    // counts cycles between period marks
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            gap_q <= '0;
            seen_q <= 1'b0;
        end else if (o_period_start) begin
            gap_q <= '0;
            seen_q <= 1'b1;
        end else begin
            gap_q <= gap_q + 16'h1;
        end
    end
    apb_answer_a: assert property (
        i_apb.psel && !i_apb.penable |=> o_apb.pready) else $error("no pready");
    loop_pulse_a: assert property (
        set_loop |=> one_pulse) else $error("loop reset pulse wrong");
    loop_cause_a: assert property (
        o_loop_reset |-> $past(set_loop)) else $error("loop reset unprompted");
    coarse_map_a: assert property (
        acc && i_apb.paddr == 12'h064 |=> ##1 o_analog.coarse_offset_ch2 == {1'b0, $past(wd, 2)})
        else $error("coarse offset wrong");
    fine_hi_a: assert property (
        acc && i_apb.paddr == 12'h068 |=> ##1 o_analog.fine_offset_ch2[8] == $past(wd[0], 2))
        else $error("fine offset bit 8 wrong");
    fine_lo_a: assert property (
        acc && i_apb.paddr == 12'h06c |=> ##1 o_analog.fine_offset_ch2[7:0] == $past(wd, 2))
        else $error("fine offset low wrong");
    gain_map_a: assert property (
        acc && i_apb.paddr == 12'h070 |=> ##1 o_analog.gain_amp_ch2 == $past(wd, 2))
        else $error("gain wrong");
    band_map_a: assert property (
        acc && i_apb.paddr == 12'h094 |=> ##1
        {1'b0, o_analog.clock_band, 2'b00, o_analog.loop_range} == ($past(wd, 2) & 8'h73))
        else $error("band or range wrong");
    cds_gate_a: assert property (
        !i_correlated_double_sampling_mode [*3] |-> !o_reset_strobe) else $error("reset strobe");
    period_gap_a: assert property (
        o_period_start && seen_q |-> gap_q == 16'(PHASE_STEPS * STEP_DIV - 1))
        else $error("pixel period length wrong");
endmodule

bind atoc_config_regs atoc_config_monitor #(.STEP_DIV(STEP_DIV)) mon (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_apb(i_apb), .o_apb(o_apb),
    .i_correlated_double_sampling_mode(i_correlated_double_sampling_mode),
    .o_analog(o_analog), .o_loop_reset(o_loop_reset), .o_reset_strobe(o_reset_strobe),
    .o_period_start(o_period_start));

// *** verification/atoc_config_regs_test.sv ***
// Purpose: self-checking bench for the config register bank
// Assumes: two clocks per phase step so step scaling shows
// Notes: host model drives apb; bench drives sampling mode and line start
module atoc_config_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    import atoc_pkg::*;
    localparam int SD = 2;
    localparam int P = PHASE_STEPS * SD;
    logic i_clk, i_reset_n, correlated_double_sampling_mode, line, lrst, rst_s, cap_s, pst, pval, e;
    atoc_apb_req_s req;
    atoc_apb_rsp_s rsp;
    atoc_analog_s ana;
    logic [31:0] q;
    int err_count = 0;
    int checks = 0;
    int cyc = 0;
    logic [5:0] idx [14] = '{6'h19, 6'h1a, 6'h1b, 6'h1c, 6'h20, 6'h21, 6'h22, 6'h23, 6'h25,
        6'h28, 6'h30, 6'h31, 6'h32, 6'h33};
    logic [7:0] base [14] = '{8'hff, 8'h00, 8'hff, 8'h61, 8'h08, 8'h1c, 8'h28, 8'h3c, 8'h02,
        8'h0f, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] mask [14] = '{8'hff, 8'h01, 8'hff, 8'hff, 8'h3f, 8'h3f, 8'h3f, 8'h3f, 8'h73,
        8'hfe, 8'hff, 8'hff, 8'hff, 8'hff};
    atoc_config_regs #(.STEP_DIV(SD)) dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_apb(req),
        .o_apb(rsp), .i_correlated_double_sampling_mode(correlated_double_sampling_mode), .i_line_start_input(line),
        .o_analog(ana), .o_loop_reset(lrst), .o_reset_strobe(rst_s), .o_capture_strobe(cap_s),
        .o_period_start(pst), .o_pattern_valid(pval));
    atoc_host_model host (.i_clk(i_clk), .i_rsp(rsp), .o_req(req));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_count++;
            end_of_test();
        end
    end
    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        host.xfer(1'b1, a, {24'h0, d}, q, e);
    endtask
    task automatic rd(input logic [11:0] a);
        host.xfer(1'b0, a, 32'h0, q, e);
    endtask
    task automatic test_regs();
        logic [7:0] v;
        for (int i = 0; i < 14; i++) begin
            rd({4'h0, idx[i], 2'b00});
            compare(q, {24'h0, base[i] & mask[i]});
        end
        compare({14'h0, ana.coarse_offset_ch2, ana.fine_offset_ch2}, 32'h1feff);
        compare({24'h0, ana.gain_amp_ch2}, 32'h61);
        for (int i = 0; i < 14; i++) begin
            v = (i == 8) ? 8'h52 : ~base[i];
            wr({4'h0, idx[i], 2'b00}, v);
            rd({4'h0, idx[i], 2'b00});
            compare(q, {24'h0, v & mask[i]});
        end
        compare({14'h0, ana.coarse_offset_ch2, ana.fine_offset_ch2}, 32'h00100);
        compare({24'h0, ana.gain_amp_ch2}, 32'h9e);
        for (int i = 0; i < 14; i++) wr({4'h0, idx[i], 2'b00}, base[i]);
    endtask
    task automatic test_bands();
        for (int c = 0; c < 6; c++) begin
            wr(12'h094, {1'b0, 3'(c), 2'b00, 2'(c % 3)});
            repeat (2) @(posedge i_clk);
            compare({27'h0, ana.clock_band, ana.loop_range}, {27'h0, 3'(c), 2'(c % 3)});
        end
    endtask
    task automatic test_loop_and_refused();
        int n = 0;
        wr(12'h0a0, 8'h01);
        repeat (4) begin
            @(posedge i_clk);
            n += int'(lrst === 1'b1);
        end
        compare(n, 1);
        rd(12'h0a0);
        compare({31'h0, q[0]}, 32'h0);
        wr(12'h074, 8'h5a);
        rd(12'h074);
        compare({q[30:0], e}, 32'h1);
        rd(12'h065);
        compare({q[30:0], e}, 32'h1);
    endtask
    // measures offset from the period mark to the strobe rise, and its width
    task automatic measure(input logic sel, output int at, output int wid);
        at = 0;
        wid = 0;
        // a whole period first, so a strobe left high by the old indices has cleared
        @(posedge i_clk iff pst === 1'b1);
        @(posedge i_clk iff pst === 1'b1);
        while ((sel ? cap_s : rst_s) !== 1'b1 && at < 2 * P) begin
            @(posedge i_clk);
            at++;
        end
        while ((sel ? cap_s : rst_s) === 1'b1 && wid < P) begin
            @(posedge i_clk);
            wid++;
        end
    endtask
    task automatic test_strobes();
        int a0, a1, w;
        wr(12'h088, 8'h04);
        wr(12'h08c, 8'h1e);
        measure(1'b1, a0, w);
        compare(w, 26 * SD);
        wr(12'h088, 8'h14);
        measure(1'b1, a1, w);
        compare(a1 - a0, 16 * SD);
        compare(w, 10 * SD);
        correlated_double_sampling_mode <= 1'b1;
        wr(12'h080, 8'h02);
        wr(12'h084, 8'h09);
        measure(1'b0, a0, w);
        compare(w, 7 * SD);
        correlated_double_sampling_mode <= 1'b0;
        measure(1'b0, a0, w);
        compare(w, 0);
    endtask
    task automatic test_pattern();
        int t = 0;
        int w = 0;
        wr(12'h0c4, 8'h02);
        wr(12'h0c8, 8'h01);
        wr(12'h0cc, 8'h01);
        @(posedge i_clk iff pst === 1'b1);
        line <= 1'b1;
        while (pval !== 1'b1 && t < 4 * P) begin
            @(posedge i_clk);
            t++;
        end
        while (pval === 1'b1 && w < 300 * P) begin
            @(posedge i_clk);
            w++;
        end
        // first pixel mark after the line edge is pixel 0; two register stages to the pin
        compare(t, 3 * P + 2);
        compare(w, 257 * P);
        line <= 1'b0;
    endtask
    initial begin
        i_reset_n = 1'b0;
        correlated_double_sampling_mode = 1'b0;
        line = 1'b0;
        repeat (3) @(posedge i_clk);
        i_reset_n <= 1'b1;
        test_regs();
        test_bands();
        test_loop_and_refused();
        test_strobes();
        test_pattern();
        end_of_test();
    end
endmodule

// *** verification/atoc_host_model.sv ***
// Purpose: host apb master that programs the register bank
// Assumes: requests launched right after a rising edge
// Notes: waits on pready without limit; the bench timeout cuts a hang
module atoc_host_model (
    input wire logic i_clk,
    input wire atoc_pkg::atoc_apb_rsp_s i_rsp,
    output atoc_pkg::atoc_apb_req_s o_req
);
    timeunit 1ns;
    timeprecision 1ps;
    import atoc_pkg::*;
    initial o_req = '0;
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
        // reserved band and range codes are never sent
        if (wr && a == 12'h094 && (d[1:0] == 2'h3 || d[6:5] == 2'h3)) return;
        @(posedge i_clk);
        o_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d, pstrb: 4'hf};
        @(posedge i_clk);
        o_req.penable <= 1'b1;
        do @(posedge i_clk); while (i_rsp.pready !== 1'b1);
        q = i_rsp.prdata;
        e = i_rsp.pslverr;
        // released lines show inverted values, not a stale copy
        o_req <= '{psel: 1'b0, penable: 1'b0, pwrite: ~wr, paddr: ~a, pwdata: ~d, pstrb: 4'h0};
    endtask
endmodule
